/* File: rtl/mwf_consts.svh */
// Offsets, field positions and reset values of the wake filter block
`ifndef MWF_CONSTS_SVH
`define MWF_CONSTS_SVH
`define MWF_OFS_FILTER      12'h128
`define MWF_OFS_CTRL        12'h12c
`define MWF_OFS_IRQ_STATUS  12'h140
`define MWF_OFS_IRQ_CLEAR   12'h144
`define MWF_OFS_IRQ_ENABLE  12'h148
`define MWF_ENTRIES         6'd40
`define MWF_LAST_ENTRY      6'd39
`define MWF_FIRST_ENTRY     6'd0
`define MWF_BIT_REWIND      31
`define MWF_BIT_GLOBAL_UNICAST_WAKE_ENABLE        9
`define MWF_BIT_OWN_SEEN    7
`define MWF_BIT_PAT_SEEN    6
`define MWF_BIT_MAGIC_SEEN  5
`define MWF_BIT_PAT_EN      2
`define MWF_BIT_RES_CLR     8
`define MWF_ZERO32          32'h0000_0000
`define MWF_RESP_OKAY       2'b00
`define MWF_RESP_SLVERR     2'b10
`endif

/* File: rtl/mwf_pkg.sv */
// Types shared by the wake filter block
package mwf_pkg;
    typedef struct packed {
        logic frame_valid;
        logic own_address_match;
        logic pattern_match;
        logic magic_match;
        logic unicast_dest;
    } mwf_rx_event_s;

    typedef struct packed {
        logic own_address_frame_seen;
        logic pattern_frame_seen;
        logic magic_frame_seen;
    } mwf_flags_s;
endpackage : mwf_pkg

/* File: rtl/mwf_wake_filter.sv */
// Wake-up pattern store, wake control and status, AXI4-Lite slave
//
// Functional notes
// RL1 - Writes fill pattern doublewords in order
// RL2 - Pointer wraps after forty entries
// RL3 - Reads return store in order
// RL4 - Software should burst forty accesses
// RL5 - Rewind bit resets both pointers, self-clears
// RL6 - Unicast enable wakes on unicast frames
// RL7 - Unicast wake also needs pattern enable
// RL8 - Own-address frame sets sticky flag
// RL9 - Pattern frame sets sticky flag
// RL10 - Magic frame sets sticky flag
// RL11 - Resume may clear the three flags
// RL12 - Pattern enable allows pattern-match wakeup
// RL13 - Write one clears flag, reserved zero
// RL14 - Event wins over same-cycle clear
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "mwf_consts.svh"

module mwf_wake_filter
    import mwf_pkg::*;
(
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [11:0]   s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [11:0]   s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire mwf_rx_event_s rx_event,
    input  wire logic          resume_done,
    output logic               wake_request,
    output logic               irq
);

    // ------------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------------
    logic [31:0] wake_pattern_store [0:39];
    logic [5:0]  wr_ptr_reg;
    logic [5:0]  rd_ptr_reg;
    logic        global_unicast_wake_enable_reg;
    logic        pattern_frame_wake_enable_reg;
    logic        resume_clears_wake_flags_reg;
    mwf_flags_s  flags_reg;
    mwf_flags_s  irq_status_reg;
    mwf_flags_s  irq_enable_reg;

    logic        aw_held_reg;
    logic        w_held_reg;
    logic [11:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;

    // ------------------------------------------------------------------
    // Write channels: address and data taken in either order
    // ------------------------------------------------------------------
    logic wr_fire;
    logic full_word;
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign full_word = &wstrb_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg   <= 1'b0;
            s_axi_awready <= 1'b0;
            awaddr_reg    <= 12'h000;
        end else if (wr_fire) begin
            aw_held_reg   <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg   <= 1'b1;
            awaddr_reg    <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (!aw_held_reg && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg   <= 1'b0;
            s_axi_wready <= 1'b0;
            wdata_reg    <= `MWF_ZERO32;
            wstrb_reg    <= 4'h0;
        end else if (wr_fire) begin
            w_held_reg   <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg   <= 1'b1;
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (!w_held_reg && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    logic wr_filter;
    logic wr_ctrl;
    logic wr_clear;
    logic wr_enable;
    logic wr_mapped;
    assign wr_filter = wr_fire && awaddr_reg == `MWF_OFS_FILTER;
    assign wr_ctrl   = wr_fire && awaddr_reg == `MWF_OFS_CTRL;
    assign wr_clear  = wr_fire && awaddr_reg == `MWF_OFS_IRQ_CLEAR;
    assign wr_enable = wr_fire && awaddr_reg == `MWF_OFS_IRQ_ENABLE;
    assign wr_mapped = wr_filter || wr_ctrl || wr_clear || wr_enable
                    || awaddr_reg == `MWF_OFS_IRQ_STATUS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `MWF_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? `MWF_RESP_OKAY : `MWF_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    logic rd_fire;
    logic rd_filter;
    assign rd_fire   = s_axi_arvalid && s_axi_arready;
    assign rd_filter = rd_fire && s_axi_araddr == `MWF_OFS_FILTER;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !rd_fire && !s_axi_rvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= `MWF_ZERO32;
            s_axi_rresp  <= `MWF_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `MWF_RESP_OKAY;
            unique case (s_axi_araddr)
                `MWF_OFS_FILTER: s_axi_rdata <= wake_pattern_store[rd_ptr_reg]; // RL3
                `MWF_OFS_CTRL: begin
                    s_axi_rdata <= `MWF_ZERO32; // RL13
                    s_axi_rdata[`MWF_BIT_GLOBAL_UNICAST_WAKE_ENABLE] <=
                        global_unicast_wake_enable_reg;
                    s_axi_rdata[`MWF_BIT_RES_CLR] <=
                        resume_clears_wake_flags_reg;
                    s_axi_rdata[`MWF_BIT_OWN_SEEN] <=
                        flags_reg.own_address_frame_seen;
                    s_axi_rdata[`MWF_BIT_PAT_SEEN] <=
                        flags_reg.pattern_frame_seen;
                    s_axi_rdata[`MWF_BIT_MAGIC_SEEN] <=
                        flags_reg.magic_frame_seen;
                    s_axi_rdata[`MWF_BIT_PAT_EN] <=
                        pattern_frame_wake_enable_reg;
                end
                `MWF_OFS_IRQ_STATUS: s_axi_rdata <= {29'h0, irq_status_reg};
                `MWF_OFS_IRQ_ENABLE: s_axi_rdata <= {29'h0, irq_enable_reg};
                `MWF_OFS_IRQ_CLEAR: s_axi_rdata <= `MWF_ZERO32;
                default: begin
                    s_axi_rdata <= `MWF_ZERO32;
                    s_axi_rresp <= `MWF_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Pattern store and its pointers
    // ------------------------------------------------------------------
    logic rewind;
    assign rewind = wr_ctrl && wdata_reg[`MWF_BIT_REWIND] && wstrb_reg[3];

    // Partial strobes still step the pointer so bursts stay aligned
    always_ff @(posedge aclk) begin
        if (wr_filter) begin
            for (int b = 0; b < 4; b++) begin
                if (wstrb_reg[b]) begin
                    wake_pattern_store[wr_ptr_reg][b*8 +: 8] <=
                        wdata_reg[b*8 +: 8]; // RL1
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || rewind) begin
            wr_ptr_reg <= `MWF_FIRST_ENTRY; // RL5
        end else if (wr_filter) begin
            wr_ptr_reg <= (wr_ptr_reg == `MWF_LAST_ENTRY) ?
                          `MWF_FIRST_ENTRY : wr_ptr_reg + 6'd1; // RL2
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || rewind) begin
            rd_ptr_reg <= `MWF_FIRST_ENTRY; // RL5
        end else if (rd_filter) begin
            rd_ptr_reg <= (rd_ptr_reg == `MWF_LAST_ENTRY) ?
                          `MWF_FIRST_ENTRY : rd_ptr_reg + 6'd1; // RL2 RL3
        end
    end

    // ------------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            global_unicast_wake_enable_reg <= 1'b0;
            pattern_frame_wake_enable_reg  <= 1'b0;
            resume_clears_wake_flags_reg   <= 1'b0;
        end else if (wr_ctrl && full_word) begin
            global_unicast_wake_enable_reg <= wdata_reg[`MWF_BIT_GLOBAL_UNICAST_WAKE_ENABLE];
            pattern_frame_wake_enable_reg  <= wdata_reg[`MWF_BIT_PAT_EN];
            resume_clears_wake_flags_reg   <= wdata_reg[`MWF_BIT_RES_CLR];
        end
    end

    // ------------------------------------------------------------------
    // Sticky received flags
    // ------------------------------------------------------------------
    mwf_flags_s set_ev;
    mwf_flags_s sw_clr;
    assign set_ev.own_address_frame_seen =
        rx_event.frame_valid && rx_event.own_address_match; // RL8
    assign set_ev.pattern_frame_seen =
        rx_event.frame_valid && rx_event.pattern_match; // RL9
    assign set_ev.magic_frame_seen =
        rx_event.frame_valid && rx_event.magic_match; // RL10
    assign sw_clr = (wr_ctrl && full_word) ?
        {wdata_reg[`MWF_BIT_OWN_SEEN], wdata_reg[`MWF_BIT_PAT_SEEN],
         wdata_reg[`MWF_BIT_MAGIC_SEEN]} : 3'b000; // RL13

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_reg <= 3'b000;
        end else begin
            // Set is applied last so a same-cycle clear loses
            flags_reg <= (flags_reg
                & ~sw_clr
                & ~{3{resume_done && resume_clears_wake_flags_reg}}) // RL11
                | set_ev; // RL14
        end
    end

    // ------------------------------------------------------------------
    // Wake request
    // ------------------------------------------------------------------
    logic unicast_wake;
    logic pattern_wake;
    assign unicast_wake = global_unicast_wake_enable_reg
        && pattern_frame_wake_enable_reg // RL7
        && rx_event.frame_valid && rx_event.unicast_dest; // RL6
    assign pattern_wake = pattern_frame_wake_enable_reg
        && set_ev.pattern_frame_seen; // RL12

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= unicast_wake || pattern_wake;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status, clear and enable
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_reg <= 3'b000;
        end else begin
            irq_status_reg <= (irq_status_reg
                & ~(wr_clear ? wdata_reg[2:0] : 3'b000)) | set_ev;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_enable_reg <= 3'b000;
        end else if (wr_enable) begin
            irq_enable_reg <= wdata_reg[2:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_reg & irq_enable_reg);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    write_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_filter && !rewind && wr_ptr_reg == `MWF_LAST_ENTRY
        |=> wr_ptr_reg == `MWF_FIRST_ENTRY) // RL2
        else $error("write pointer did not wrap");
    write_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_filter && !rewind && wr_ptr_reg != `MWF_LAST_ENTRY
        |=> wr_ptr_reg == $past(wr_ptr_reg) + 6'd1) // RL1
        else $error("write pointer did not step");
    read_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_filter && !rewind
        |=> rd_ptr_reg == (($past(rd_ptr_reg) == `MWF_LAST_ENTRY) ?
            `MWF_FIRST_ENTRY : $past(rd_ptr_reg) + 6'd1)) // RL3
        else $error("read pointer did not step");
    ptr_rewind_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rewind |=> wr_ptr_reg == `MWF_FIRST_ENTRY
            && rd_ptr_reg == `MWF_FIRST_ENTRY) // RL5
        else $error("rewind did not reset pointers");
    unicast_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
        unicast_wake |=> wake_request) // RL6
        else $error("unicast frame gave no wake");
    unicast_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !pattern_frame_wake_enable_reg |=> !wake_request) // RL7
        else $error("wake without pattern enable");
    own_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        set_ev.own_address_frame_seen
        |=> flags_reg.own_address_frame_seen) // RL8
        else $error("own address flag not set");
    pattern_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        set_ev.pattern_frame_seen |=> flags_reg.pattern_frame_seen) // RL9
        else $error("pattern flag not set");
    magic_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        set_ev.magic_frame_seen |=> flags_reg.magic_frame_seen) // RL10
        else $error("magic flag not set");
    resume_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        resume_done && resume_clears_wake_flags_reg && set_ev == 3'b000
        |=> flags_reg == 3'b000) // RL11
        else $error("resume did not clear flags");

    pattern_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pattern_wake |=> wake_request) // RL12
        else $error("pattern match gave no wake");

    sw_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sw_clr[0] && !set_ev.magic_frame_seen
        |=> !flags_reg.magic_frame_seen) // RL13
        else $error("write one did not clear flag");

    set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sw_clr[2] && set_ev.own_address_frame_seen
        |=> flags_reg.own_address_frame_seen) // RL14
        else $error("event lost to clear");

endmodule : mwf_wake_filter

/* File: tb/mwf_rx_model.sv */
// Receive path stand-in that hands frame events to the wake filter block
`timescale 1ns/1ns

module mwf_rx_model
    import mwf_pkg::*;
(
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          send,
    input  wire mwf_rx_event_s send_event,
    output mwf_rx_event_s      rx_event
);
    // ------------------------------------------------------------
    // Event delivery
    // ------------------------------------------------------------
    // One pulse per requested cycle; quiet otherwise, so no event
    // can be counted twice by a held value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_event <= '0;
        end else if (send) begin
            rx_event <= send_event;
        end else begin
            rx_event <= '0;
        end
    end
endmodule : mwf_rx_model

/* File: tb/tb.sv */
// Self-checking testbench for the wake filter block
`timescale 1ns/1ns
`include "mwf_consts.svh"

module tb
    import mwf_pkg::*;
;
    logic          aclk;
    logic          aresetn;
    logic [11:0]   awaddr;
    logic          awvalid;
    logic          awready;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          wvalid;
    logic          wready;
    logic [1:0]    bresp;
    logic          bvalid;
    logic          bready;
    logic [11:0]   araddr;
    logic          arvalid;
    logic          arready;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic          rvalid;
    logic          rready;
    logic          send;
    mwf_rx_event_s send_event;
    mwf_rx_event_s rx_event;
    logic          resume_done;
    logic          wake_request;
    logic          irq;
    logic          woke;
    logic [31:0]   rd;
    logic [1:0]    rs;
    int            err_count;
    int            compares;
    int            cycles;

    mwf_wake_filter mwf_wake_filter_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rx_event(rx_event),
        .resume_done(resume_done), .wake_request(wake_request),
        .irq(irq)
    );

    mwf_rx_model mwf_rx_model_inst (
        .aclk(aclk), .aresetn(aresetn), .send(send),
        .send_event(send_event), .rx_event(rx_event)
    );

    // ------------------------------------------------------------
    // Clock, watchdog and verdict
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic end_sim;
        if (err_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    // About 550 cycles of traffic; generous margin for slow answers
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_count++;
            end_sim;
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask : chk

    // ------------------------------------------------------------
    // Bus master
    // ------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hf);
        bit ad;
        bit wd;
        ad = 0;
        wd = 0;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && awready === 1'b1) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (!wd && wready === 1'b1) begin
                wd = 1;
                wvalid <= 1'b0;
            end
        end
        @(posedge aclk);
        while (bvalid !== 1'b1) @(posedge aclk);
        rs = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rdr(input logic [11:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        @(posedge aclk);
        while (arready !== 1'b1) @(posedge aclk);
        arvalid <= 1'b0;
        @(posedge aclk);
        while (rvalid !== 1'b1) @(posedge aclk);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : rdr

    task automatic rchk(input string nm, input logic [11:0] a,
                        input logic [31:0] e);
        rdr(a);
        chk(nm, e, rd);
    endtask : rchk

    // One frame event, then watch four edges for a wake pulse
    task automatic ev(input logic [4:0] e);
        @(posedge aclk);
        send       <= 1'b1;
        send_event <= e;
        @(posedge aclk);
        send <= 1'b0;
        woke = 1'b0;
        repeat (4) begin
            @(posedge aclk);
            if (wake_request === 1'b1) woke = 1'b1;
        end
    endtask : ev

    function automatic logic [31:0] pat(input int i);
        return 32'h5a00_0000 + i * 32'h0001_0203;
    endfunction : pat

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rchk("ctrl", `MWF_OFS_CTRL, 32'h0000_0000);
        chk("rd resp", {30'h0, `MWF_RESP_OKAY}, {30'h0, rs});
        rchk("irq_st", `MWF_OFS_IRQ_STATUS, 32'h0000_0000);
        chk("irq", 32'h0, {31'h0, irq});
        rchk("unmapped", 12'h200, 32'h0000_0000);
        chk("unmapped resp", {30'h0, `MWF_RESP_SLVERR}, {30'h0, rs});
        wr(12'h200, 32'h0000_0001);
        chk("wr unmapped", {30'h0, `MWF_RESP_SLVERR}, {30'h0, rs});
    endtask : t_reset

    task automatic t_store;
        for (int i = 0; i < 40; i++) wr(`MWF_OFS_FILTER, pat(i));
        chk("wr resp", {30'h0, `MWF_RESP_OKAY}, {30'h0, rs});
        wr(`MWF_OFS_FILTER, 32'h0bad_0040);
        for (int i = 0; i < 40; i++) begin
            rchk("store", `MWF_OFS_FILTER,
                 i == 0 ? 32'h0bad_0040 : pat(i));
        end
        rchk("rd wrap", `MWF_OFS_FILTER, 32'h0bad_0040);
        rdr(`MWF_OFS_FILTER);
        wr(`MWF_OFS_CTRL, 32'h8000_0000, 4'h8);
        rchk("rd rewind", `MWF_OFS_FILTER, 32'h0bad_0040);
        wr(`MWF_OFS_FILTER, 32'h1234_5678);
        wr(`MWF_OFS_CTRL, 32'h8000_0000);
        rchk("wr rewind", `MWF_OFS_FILTER, 32'h1234_5678);
        rchk("self clear", `MWF_OFS_CTRL, 32'h0000_0000);
    endtask : t_store

    task automatic t_flags;
        wr(`MWF_OFS_CTRL, 32'h7fff_fc1b);
        rchk("reserved", `MWF_OFS_CTRL, 32'h0000_0000);
        wr(`MWF_OFS_CTRL, 32'h0000_0204, 4'h7);
        rchk("part strb", `MWF_OFS_CTRL, 32'h0000_0000);
        ev(5'h08);
        rchk("no valid", `MWF_OFS_CTRL, 32'h0000_0000);
        ev(5'h18);
        rchk("own seen", `MWF_OFS_CTRL, 32'h0000_0080);
        ev(5'h14);
        ev(5'h12);
        rchk("all seen", `MWF_OFS_CTRL, 32'h0000_00e0);
        wr(`MWF_OFS_CTRL, 32'h0000_0080);
        rchk("w1c", `MWF_OFS_CTRL, 32'h0000_0060);
        wr(`MWF_OFS_CTRL, 32'h0000_0000);
        rchk("w0", `MWF_OFS_CTRL, 32'h0000_0060);
        wr(`MWF_OFS_CTRL, 32'h0000_0060);
        rchk("w1c all", `MWF_OFS_CTRL, 32'h0000_0000);
    endtask : t_flags

    // One event, on the very cycle the clear executes and no other,
    // so a lost set cannot be hidden by a later event
    task automatic t_race;
        send_event <= 5'h18;
        fork
            wr(`MWF_OFS_CTRL, 32'h0000_0080);
            begin
                @(posedge aclk);
                send <= 1'b1;
                @(posedge aclk);
                send <= 1'b0;
            end
        join
        repeat (2) @(posedge aclk);
        rchk("set wins", `MWF_OFS_CTRL, 32'h0000_0080);
        wr(`MWF_OFS_CTRL, 32'h0000_0080);
    endtask : t_race

    task automatic t_resume;
        for (int k = 1; k >= 0; k--) begin
            wr(`MWF_OFS_CTRL, k ? 32'h0000_0100 : 32'h0000_0000);
            ev(5'h18);
            @(posedge aclk);
            resume_done <= 1'b1;
            @(posedge aclk);
            resume_done <= 1'b0;
            rchk("resume", `MWF_OFS_CTRL,
                 k ? 32'h0000_0100 : 32'h0000_0080);
        end
        wr(`MWF_OFS_CTRL, 32'h0000_0080);
    endtask : t_resume

    task automatic t_wake;
        logic [31:0] ctl [5] = '{32'h0000_0200, 32'h0000_0204,
                                 32'h0000_0204, 32'h0000_0004,
                                 32'h0000_0000};
        logic [4:0]  evs [5] = '{5'h11, 5'h11, 5'h10, 5'h14, 5'h14};
        logic        wk  [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 5; i++) begin
            wr(`MWF_OFS_CTRL, ctl[i]);
            ev(evs[i]);
            chk("wake", {31'h0, wk[i]}, {31'h0, woke});
        end
        wr(`MWF_OFS_CTRL, 32'h0000_00e0);
    endtask : t_wake

    task automatic t_irq;
        wr(`MWF_OFS_IRQ_CLEAR, 32'h0000_0007);
        wr(`MWF_OFS_IRQ_ENABLE, 32'h0000_0000);
        ev(5'h12);
        rchk("irq st", `MWF_OFS_IRQ_STATUS, 32'h0000_0001);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`MWF_OFS_IRQ_ENABLE, 32'h0000_0001);
        repeat (2) @(posedge aclk);
        chk("irq on", 32'h1, {31'h0, irq});
        rchk("irq en", `MWF_OFS_IRQ_ENABLE, 32'h0000_0001);
        wr(`MWF_OFS_IRQ_CLEAR, 32'h0000_0001);
        rchk("irq clr", `MWF_OFS_IRQ_STATUS, 32'h0000_0000);
        repeat (2) @(posedge aclk);
        chk("irq off", 32'h0, {31'h0, irq});
        rchk("clr reads 0", `MWF_OFS_IRQ_CLEAR, 32'h0000_0000);
    endtask : t_irq

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        err_count   = 0;
        compares    = 0;
        cycles      = 0;
        aresetn     = 1'b0;
        awaddr      = 12'h000;
        awvalid     = 1'b0;
        wdata       = 32'h0000_0000;
        wstrb       = 4'hf;
        wvalid      = 1'b0;
        bready      = 1'b0;
        araddr      = 12'h000;
        arvalid     = 1'b0;
        rready      = 1'b0;
        send        = 1'b0;
        send_event  = '0;
        resume_done = 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_store;
        t_flags;
        t_race;
        t_resume;
        t_wake;
        t_irq;
        end_sim;
    end
endmodule : tb
